// ===== bench/tb_tcagc_ctrl.sv
// Self-checking bench for the time-of-day control block.
// Assumes the far-side model in tcagc_far drives the GPI pin and timecode input.
`timescale 1ns/10ps
module tb_tcagc_ctrl;
	import tcagc_pkg::*;
	localparam int unsigned SEC = 8;
	logic ref_clk_i = 1'b0, rstn_i = 1'b0, cfg_load_i = 1'b0, pt_apply_i = 1'b0;
	logic loss_of_lock_i = 1'b0, sig_warn_i = 1'b0, sat_unlock_i = 1'b0, tod_ref_ltc_i = 1'b0;
	logic gpi_i, reading_i = 1'b0, tc_in_frame_i, tc_in_valid_i, press = 1'b0, feed = 1'b0;
	logic [3:0] reading_sats_i = 4'h4;
	tcagc_cfg_t cfg_i = CFG_RST;
	tcagc_hms_t pt_preset_i = '0, pt_o, pt_seen;
	tcagc_ref_t ref_mode_i = TCAGC_REF_SATELLITE;
	tcagc_tod_t tod_i = '0;
	tcagc_tc_t tc_in_i, tc_set = '0, tc_out_o, tod_value_o;
	tcagc_fmt_t fmt_o;
	logic [10:0] epoch_year_o;
	logic [15:0] ltc_delay_us_o;
	logic alarm_o, gpo_o, gpo_oe_o, blank_o, first_timecode_port_out_o, tc_on_o;
	logic reacq_busy_o, pos_store_o, jam_sync_o, tod_load_o, hung = 1'b0;
	logic [15:0] lim [5] = '{LIM_2398_US, LIM_24_US, LIM_25_US, LIM_30_US, LIM_30DROP_US};
	logic [22:0] expq [$];
	int miscompares = 0, n_compared = 0, seed = 32'hf8f7ad0a, cnt;

	always #20 ref_clk_i = ~ref_clk_i;
	tcagc_ctrl #(.SEC_CYCLES(SEC)) u_tcagc_ctrl (.ref_clk_i, .rstn_i, .cfg_i, .cfg_load_i, .pt_preset_i,
		.pt_apply_i, .loss_of_lock_i, .sig_warn_i, .sat_unlock_i, .tod_ref_ltc_i, .ref_mode_i, .tod_i,
		.gpi_i, .reading_i, .reading_sats_i, .tc_in_i, .tc_in_frame_i, .tc_in_valid_i, .epoch_year_o,
		.alarm_o, .gpo_o, .gpo_oe_o, .blank_o, .first_timecode_port_out_o, .tc_out_o, .tc_on_o, .fmt_o,
		.ltc_delay_us_o, .pt_o, .reacq_busy_o, .pos_store_o, .jam_sync_o, .tod_load_o, .tod_value_o);
	tcagc_far u_tcagc_far (.clk_i(ref_clk_i), .press_i(press), .feed_i(feed), .tc_set_i(tc_set),
		.gpi_o(gpi_i), .tc_o(tc_in_i), .frame_o(tc_in_frame_i), .valid_o(tc_in_valid_i));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic load();
		cfg_load_i = 1'b1;
		@(negedge ref_clk_i);
		cfg_load_i = 1'b0;
		repeat (2) @(negedge ref_clk_i);
	endtask
	task automatic push();
		press = 1'b1;
		repeat (10) @(negedge ref_clk_i);
		press = 1'b0;
		repeat (6) @(negedge ref_clk_i);
	endtask
	task automatic cond_run(input int k, input logic [31:0] exp);
		{sat_unlock_i, sig_warn_i, loss_of_lock_i} = 3'(1 << k);
		repeat (SEC) @(negedge ref_clk_i);
		check({blank_o, gpo_oe_o}, 0);
		repeat (SEC + 4) @(negedge ref_clk_i);
		check({blank_o, gpo_oe_o}, exp);
		{sat_unlock_i, sig_warn_i, loss_of_lock_i} = 3'h0;
		repeat (4) @(negedge ref_clk_i);
		check({blank_o, gpo_oe_o}, 0);
	endtask

	// Scoreboard: every jam pulse must match the oldest expected note.
	always @(posedge ref_clk_i) begin
		#1;
		if (jam_sync_o !== 1'b0)
			check({tod_load_o, tod_value_o}, expq.size() ? expq.pop_front() : 32'hFFFFFFFF);
	end

	// A hung wait in the main sequence ends the run here as well as the overall limit.
	initial begin
		for (int t = 0; t < 75_000 && !hung; t++)
			@(negedge ref_clk_i);
		miscompares++;
		report_and_stop();
	end

	initial begin
		repeat (10) @(negedge ref_clk_i);
		rstn_i = 1'b1;
		check({epoch_year_o, fmt_o}, {EPOCH_NEW_YEAR, TCAGC_FMT_25});
		@(negedge ref_clk_i);
		check(tc_on_o, 1);
		cfg_i.epoch_1958 = 1'b1;
		cfg_i.port_out = 1'b1;
		cfg_i.delay_us = -16'sh7D00;
		cfg_i.src = TCAGC_SRC_UTC;
		cfg_i.offset = {5'h01, 6'h2D, 6'h28, 5'h14};
		tod_i.utc = {5'h0A, 6'h14, 6'h1E, 5'h0A};
		for (int f = 4; f >= 0; f--) begin
			cfg_i.fmt = tcagc_fmt_t'(f);
			load();
			check(fmt_o, f);
			check(ltc_delay_us_o, 16'(0 - lim[f]));
		end
		check(tc_out_o, {5'h0C, 6'h06, 6'h0B, 5'h06});
		check({epoch_year_o, first_timecode_port_out_o}, {EPOCH_OLD_YEAR, 1'b1});
		cfg_i.offset = '0;
		tod_i.local_time_with_daylight_saving = {5'h01, 6'h02, 6'h03, 5'h04};
		tod_i.local_std = {5'h05, 6'h06, 6'h07, 5'h08};
		for (int s = 1; s < 5; s++) begin
			cfg_i.src = tcagc_src_t'(s);
			load();
			pt_seen = pt_o;
			@(negedge ref_clk_i);
			check(tc_out_o, s == 1 ? tod_i.local_time_with_daylight_saving : s == 2 ? tod_i.local_std : s == 3 ? tod_i.utc : {pt_seen, 5'h00});
		end
		tod_ref_ltc_i = 1'b1;
		cfg_i.src = TCAGC_SRC_DISABLED;
		load();
		check({tc_on_o, first_timecode_port_out_o}, 0);
		$display("config test done");
		cfg_i.lol_delay = 17'h00002;
		cfg_i.warn_delay = 17'h00002;
		cfg_i.blank_delay = 17'h00002;
		for (int k = 0; k < 4; k++) begin
			cfg_i.gpo_sel = k[0] ? TCAGC_GPO_SIG_WARN : TCAGC_GPO_LOSS_LOCK;
			cfg_i.blank_en = (k == 3);
			load();
			cond_run(k > 2 ? 2 : k, k == 3 ? 2 : (k < 2));
		end
		$display("delay test done");
		pt_preset_i = {5'h05, 6'h00, 6'h00};
		pt_apply_i = 1'b1;
		@(negedge ref_clk_i);
		pt_apply_i = 1'b0;
		check(pt_o, pt_preset_i);
		cfg_i.gpi_fn = TCAGC_GPI_RESET_PT;
		cfg_i.alarm_en = 1'b1;
		cfg_i.alarm_time = {5'h00, 6'h00, 6'h05};
		cfg_i.gpo_sel = TCAGC_GPO_ALARM_TIME;
		load();
		push();
		check(pt_o < 17'h00005, 1);
		cnt = 0;
		while (alarm_o !== 1'b1 && cnt < 8 * SEC) begin
			@(negedge ref_clk_i);
			cnt++;
		end
		if (alarm_o !== 1'b1)
			hung = 1'b1;
		check(pt_o, cfg_i.alarm_time);
		cnt = 0;
		while (alarm_o === 1'b1 && cnt < 2 * SEC) begin
			@(negedge ref_clk_i);
			cnt++;
			if (cnt == 1)
				check({gpo_oe_o, gpo_o}, 2'h2);
		end
		if (alarm_o === 1'b1)
			hung = 1'b1;
		check(cnt, SEC);
		$display("alarm test done");
		cfg_i.gpi_fn = TCAGC_GPI_REACQUIRE;
		load();
		push();
		check(reacq_busy_o, 1);
		for (int i = 0; i < 63; i++) begin
			reading_sats_i = i < 3 ? 4'h3 : 4'h4;
			reading_i = 1'b1;
			@(negedge ref_clk_i);
			reading_i = 1'b0;
			check(pos_store_o, i == 62);
			@(negedge ref_clk_i);
		end
		check(reacq_busy_o, 0);
		$display("reacquire test done");
		cfg_i.gpi_fn = TCAGC_GPI_JAM_SYNC;
		ref_mode_i = TCAGC_REF_VERTICAL_INTERVAL_TIMECODE_MODE;
		load();
		push();
		for (int j = 0; j < 2; j++) begin
			tc_set = tcagc_tc_t'($random(seed));
			feed = 1'b1;
			repeat (220) @(negedge ref_clk_i);
			expq.push_back({~j[0], tc_set});
			push();
			ref_mode_i = TCAGC_REF_SATELLITE;
		end
		check(expq.size(), 0);
		$display("jam sync test done");
		report_and_stop();
	end
endmodule

// ===== bench/tcagc_far.sv
// Far-side studio gear: a GPI contact closure and an incoming timecode feed.
// Assumes the bench commands it away from the rising clock edge.
`timescale 1ns/10ps
module tcagc_far
	import tcagc_pkg::*;
(
	input  wire logic      clk_i,
	input  wire logic      press_i,
	input  wire logic      feed_i,
	input  wire tcagc_tc_t tc_set_i,
	output logic           gpi_o,
	output tcagc_tc_t      tc_o,
	output logic           frame_o,
	output logic           valid_o
);
	assign gpi_o = press_i ? 1'b0 : 1'b1;
	// A dead feed shows changing junk, not the last good code.
	always @(posedge clk_i) begin
		frame_o <= feed_i & ~frame_o;
		valid_o <= feed_i;
		tc_o <= feed_i ? tc_set_i : ~tc_o;
	end
	initial begin
		frame_o = 1'b0;
		valid_o = 1'b0;
		tc_o = '0;
	end
endmodule

// ===== rtl/tcagc_ctrl.sv
// Time-of-day control: epoch, program-time alarm, alarm delays, timecode output setup and GPI actions.
// Assumes status inputs come from logic on ref_clk_i; only the GPI pin is asynchronous.
`timescale 1ns/10ps
// Behaviour
// - Epoch is 1970 or 1958, taken when a configuration load confirms it.
// - Alarm fires when enabled and the program-time counter reaches the alarm time.
// - Loss of lock reaches the output only after its programmed delay.
// - Signal warning reaches the output only after its own programmed delay.
// - Second black-burst blanking waits its programmed delay after satellite unlock.
// - Blanking delay matters only when blanking on unlock is enabled.
// - First timecode port is input whenever the timecode reference is selected.
// - Five output formats: 23.98, 24, 25, 30 and 30 drop frame.
// - Output timecode delay is clamped to the range of the current format.
// - Output source is disabled, local with or without DST, UTC or program time.
// - Programmable offset in hours to frames is added to the source.
// - GPI idles high; pulling it low requests the selected function.
// - GPI function: none, program-time reset, reacquire position or jam sync.
// - Reacquisition stores a position after sixty readings from four satellites.
// - In satellite mode a GPI jam sync is applied at once.
// - In vertical interval mode a GPI jam sync also loads the instrument time.
// - GPI jam sync needs one hundred consecutive valid incoming frames.
// - Alarm indication lasts exactly one second.
// - GPO is open collector, driven low while the selected alarm is active.
module tcagc_ctrl
	import tcagc_pkg::*;
#(
	parameter int unsigned SEC_CYCLES = SEC_CYCLES_DEF
) (
	input  wire logic       ref_clk_i,
	input  wire logic       rstn_i,
	input  wire tcagc_cfg_t cfg_i,
	input  wire logic       cfg_load_i,
	input  wire tcagc_hms_t pt_preset_i,
	input  wire logic       pt_apply_i,
	input  wire logic       loss_of_lock_i,
	input  wire logic       sig_warn_i,
	input  wire logic       sat_unlock_i,
	input  wire logic       tod_ref_ltc_i,
	input  wire tcagc_ref_t ref_mode_i,
	input  wire tcagc_tod_t tod_i,
	input  wire logic       gpi_i,
	input  wire logic       reading_i,
	input  wire logic [3:0] reading_sats_i,
	input  wire tcagc_tc_t  tc_in_i,
	input  wire logic       tc_in_frame_i,
	input  wire logic       tc_in_valid_i,
	output logic [10:0]     epoch_year_o,
	output logic            alarm_o,
	output logic            gpo_o,
	output logic            gpo_oe_o,
	output logic            blank_o,
	output logic            first_timecode_port_out_o,
	output tcagc_tc_t       tc_out_o,
	output logic            tc_on_o,
	output tcagc_fmt_t      fmt_o,
	output logic [15:0]     ltc_delay_us_o,
	output tcagc_hms_t      pt_o,
	output logic            reacq_busy_o,
	output logic            pos_store_o,
	output logic            jam_sync_o,
	output logic            tod_load_o,
	output tcagc_tc_t       tod_value_o
);

	localparam tcagc_tc_t PT_STEP = '{hms: '{hh: 5'h00, mm: 6'h00, ss: 6'h01}, ff: 5'h00};

	tcagc_cfg_t   cfg_r;
	logic [24:0]  sec_cnt_r;
	logic         sec_tick;
	tcagc_tc_t    ptc_r;
	tcagc_tc_t    pt_inc;
	logic         alarm_r;
	logic         lol_rep;
	logic         warn_rep;
	logic         blank_rep;
	logic         gpo_oe_r;
	logic         gpo_r;
	logic         blank_r;
	logic         port_out_r;
	logic [10:0]  epoch_r;
	tcagc_tc_t    src_sel;
	tcagc_tc_t    tc_out_r;
	logic         tc_on_r;
	tcagc_fmt_t   fmt_r;
	logic signed [15:0] lim_w;
	logic signed [15:0] dly_r;
	logic         gpi_s1_r;
	logic         gpi_s2_r;
	logic         gpi_s3_r;
	logic         gpi_lvl_r;
	logic         gpi_fall;
	logic [6:0]   vfr_cnt_r;
	logic         frames_ok;
	logic         jam_r;
	logic         tod_load_r;
	tcagc_tc_t    tod_val_r;
	tcagc_rq_st_t rq_st_r;
	tcagc_rq_st_t rq_st_nxt;
	logic [5:0]   rd_cnt_r;
	logic         good_rd;
	logic         busy_r;
	logic         store_r;

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cfg_r <= CFG_RST;
		end else if (cfg_load_i) begin
			cfg_r <= cfg_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			epoch_r <= EPOCH_NEW_YEAR;
		end else begin
			epoch_r <= cfg_r.epoch_1958 ? EPOCH_OLD_YEAR : EPOCH_NEW_YEAR;
		end
	end

	// The seconds prescaler runs free, so program time steps on whole-second boundaries only.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sec_cnt_r <= 25'h0000000;
		end else if (sec_tick) begin
			sec_cnt_r <= 25'h0000000;
		end else begin
			sec_cnt_r <= sec_cnt_r + 25'h0000001;
		end
	end

	assign sec_tick = sec_cnt_r == 25'(SEC_CYCLES - 1);
	assign pt_inc = tc_add(ptc_r, PT_STEP, FPS_24);

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ptc_r <= '0;
		end else if (pt_apply_i) begin
			ptc_r <= '{hms: pt_preset_i, ff: 5'h00};
		end else if (gpi_fall && cfg_r.gpi_fn == TCAGC_GPI_RESET_PT) begin
			ptc_r <= '0;
		end else if (sec_tick) begin
			ptc_r <= pt_inc;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			alarm_r <= 1'h0;
		end else if (sec_tick) begin
			alarm_r <= cfg_r.alarm_en && !pt_apply_i && !(gpi_fall && cfg_r.gpi_fn == TCAGC_GPI_RESET_PT)
				&& pt_inc.hms == cfg_r.alarm_time;
		end
	end

	tcagc_delay u_lol_dly (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.cond_i    (loss_of_lock_i),
		.tick_i    (sec_tick),
		.delay_s_i (hms_to_s(cfg_r.lol_delay)),
		.report_o  (lol_rep)
	);

	tcagc_delay u_warn_dly (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.cond_i    (sig_warn_i),
		.tick_i    (sec_tick),
		.delay_s_i (hms_to_s(cfg_r.warn_delay)),
		.report_o  (warn_rep)
	);

	tcagc_delay u_blank_dly (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.cond_i    (sat_unlock_i && cfg_r.blank_en),
		.tick_i    (sec_tick),
		.delay_s_i (hms_to_s(cfg_r.blank_delay)),
		.report_o  (blank_rep)
	);

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gpo_oe_r <= 1'h0;
			gpo_r <= 1'h0;
		end else begin
			gpo_r <= 1'h0;
			case (cfg_r.gpo_sel)
				TCAGC_GPO_SIG_WARN: gpo_oe_r <= warn_rep;
				TCAGC_GPO_LOSS_LOCK: gpo_oe_r <= lol_rep;
				TCAGC_GPO_ALARM_TIME: gpo_oe_r <= alarm_r;
				default: gpo_oe_r <= 1'h0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			blank_r <= 1'h0;
			port_out_r <= 1'h0;
		end else begin
			blank_r <= blank_rep && cfg_r.blank_en;
			port_out_r <= cfg_r.port_out && !tod_ref_ltc_i;
		end
	end

	always_comb begin
		case (cfg_r.src)
			TCAGC_SRC_LOCAL_TIME_WITH_DAYLIGHT_SAVING: src_sel = tod_i.local_time_with_daylight_saving;
			TCAGC_SRC_LOCAL_TIME_WITHOUT_DAYLIGHT_SAVING: src_sel = tod_i.local_std;
			TCAGC_SRC_UTC: src_sel = tod_i.utc;
			TCAGC_SRC_PROGRAM_TIME: src_sel = ptc_r;
			default: src_sel = '0;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tc_out_r <= '0;
			tc_on_r <= 1'h0;
			fmt_r <= TCAGC_FMT_25;
		end else begin
			tc_out_r <= tc_add(src_sel, cfg_r.offset, fmt_fps(cfg_r.fmt));
			tc_on_r <= cfg_r.src != TCAGC_SRC_DISABLED;
			fmt_r <= cfg_r.fmt;
		end
	end

	assign lim_w = $signed(fmt_lim(cfg_r.fmt));

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dly_r <= 16'sh0000;
		end else if (cfg_r.delay_us > lim_w) begin
			dly_r <= lim_w;
		end else if (cfg_r.delay_us < -lim_w) begin
			dly_r <= -lim_w;
		end else begin
			dly_r <= cfg_r.delay_us;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gpi_s1_r <= 1'h1;
			gpi_s2_r <= 1'h1;
			gpi_s3_r <= 1'h1;
			gpi_lvl_r <= 1'h1;
		end else begin
			gpi_s1_r <= gpi_i;
			gpi_s2_r <= gpi_s1_r;
			gpi_s3_r <= gpi_s2_r;
			if (gpi_s2_r == gpi_s3_r) begin
				gpi_lvl_r <= gpi_s2_r;
			end
		end
	end

	assign gpi_fall = gpi_lvl_r && !gpi_s2_r && !gpi_s3_r;

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			vfr_cnt_r <= 7'h00;
		end else if (!tc_in_valid_i) begin
			vfr_cnt_r <= 7'h00;
		end else if (tc_in_frame_i && !frames_ok) begin
			vfr_cnt_r <= vfr_cnt_r + 7'h01;
		end
	end

	assign frames_ok = vfr_cnt_r == JAM_MIN_FRAMES;

	// Jam sync in either reference mode, with a time load in vertical interval mode only.
	// A request without a long enough valid run is dropped, not held for later.
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			jam_r <= 1'h0;
			tod_load_r <= 1'h0;
			tod_val_r <= '0;
		end else begin
			jam_r <= gpi_fall && cfg_r.gpi_fn == TCAGC_GPI_JAM_SYNC && frames_ok;
			tod_load_r <= gpi_fall && cfg_r.gpi_fn == TCAGC_GPI_JAM_SYNC && frames_ok
				&& ref_mode_i == TCAGC_REF_VERTICAL_INTERVAL_TIMECODE_MODE;
			if (gpi_fall && cfg_r.gpi_fn == TCAGC_GPI_JAM_SYNC && frames_ok) begin
				tod_val_r <= tc_in_i;
			end
		end
	end

	assign good_rd = reading_i && reading_sats_i >= REACQ_MIN_SATS;

	always_comb begin
		case (rq_st_r)
			TCAGC_RQ_IDLE: rq_st_nxt = (gpi_fall && cfg_r.gpi_fn == TCAGC_GPI_REACQUIRE) ? TCAGC_RQ_GATHER
				: TCAGC_RQ_IDLE;
			TCAGC_RQ_GATHER: rq_st_nxt = (good_rd && rd_cnt_r == REACQ_READINGS - 6'h01) ? TCAGC_RQ_STORE
				: TCAGC_RQ_GATHER;
			default: rq_st_nxt = TCAGC_RQ_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rq_st_r <= TCAGC_RQ_IDLE;
			rd_cnt_r <= 6'h00;
			busy_r <= 1'h0;
			store_r <= 1'h0;
		end else begin
			rq_st_r <= rq_st_nxt;
			busy_r <= rq_st_nxt != TCAGC_RQ_IDLE;
			store_r <= rq_st_nxt == TCAGC_RQ_STORE;
			if (rq_st_r == TCAGC_RQ_IDLE) begin
				rd_cnt_r <= 6'h00;
			end else if (rq_st_r == TCAGC_RQ_GATHER && good_rd) begin
				rd_cnt_r <= rd_cnt_r + 6'h01;
			end
		end
	end

	assign epoch_year_o = epoch_r;
	assign alarm_o = alarm_r;
	assign gpo_o = gpo_r;
	assign gpo_oe_o = gpo_oe_r;
	assign blank_o = blank_r;
	assign first_timecode_port_out_o = port_out_r;
	assign tc_out_o = tc_out_r;
	assign tc_on_o = tc_on_r;
	assign fmt_o = fmt_r;
	assign ltc_delay_us_o = dly_r;
	assign pt_o = ptc_r.hms;
	assign reacq_busy_o = busy_r;
	assign pos_store_o = store_r;
	assign jam_sync_o = jam_r;
	assign tod_load_o = tod_load_r;
	assign tod_value_o = tod_val_r;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);

	epoch_follow_a: assert property (
		cfg_load_i |=> ##1 epoch_year_o == ($past(cfg_i.epoch_1958, 2) ? EPOCH_OLD_YEAR : EPOCH_NEW_YEAR))
		else $error("epoch year does not follow the confirmed choice");
	alarm_match_a: assert property (
		$rose(alarm_o) |-> $past(sec_tick) && pt_o == $past(cfg_r.alarm_time) && $past(cfg_r.alarm_en))
		else $error("alarm raised without a program time match");
	alarm_length_a: assert property (
		$changed(alarm_o) |-> $past(sec_tick))
		else $error("alarm changed away from a second boundary");
	blank_gate_a: assert property (
		!cfg_r.blank_en |=> !blank_o)
		else $error("blanking while not configured");
	port_forced_a: assert property (
		tod_ref_ltc_i |=> !first_timecode_port_out_o)
		else $error("timecode port driven as output while it is the reference");
	delay_range_a: assert property (
		$signed(ltc_delay_us_o) <= $past(lim_w) && $signed(ltc_delay_us_o) >= -$past(lim_w))
		else $error("output timecode delay outside the format range");
	gpo_alarm_a: assert property (
		cfg_r.gpo_sel == TCAGC_GPO_ALARM_TIME && alarm_r |=> gpo_oe_o && !gpo_o)
		else $error("open collector output not pulled low for the alarm");
	jam_once_a: assert property (
		jam_sync_o |=> !jam_sync_o ##1 !jam_sync_o)
		else $error("jam sync repeated for one input fall");
	jam_frames_a: assert property (
		jam_sync_o |-> $past(vfr_cnt_r) == JAM_MIN_FRAMES && $past(cfg_r.gpi_fn) == TCAGC_GPI_JAM_SYNC)
		else $error("jam sync without one hundred valid frames");
	jam_sat_a: assert property (
		gpi_fall && cfg_r.gpi_fn == TCAGC_GPI_JAM_SYNC && frames_ok
		&& ref_mode_i == TCAGC_REF_SATELLITE |=> jam_sync_o && !tod_load_o)
		else $error("satellite mode jam sync not applied alone");
	tod_load_a: assert property (
		tod_load_o |-> jam_sync_o && tod_value_o == $past(tc_in_i))
		else $error("time load without jam sync or with a stale value");
	pos_store_a: assert property (
		pos_store_o |-> rd_cnt_r == REACQ_READINGS && $past(reacq_busy_o))
		else $error("position stored before sixty good readings");
	pt_reset_a: assert property (
		gpi_fall && cfg_r.gpi_fn == TCAGC_GPI_RESET_PT && !pt_apply_i |=> pt_o == '0)
		else $error("program time not cleared by the input");

	alarm_seen_c: cover property ($rose(alarm_o));
	jam_seen_c: cover property (tod_load_o);
	store_seen_c: cover property (pos_store_o);
	blank_seen_c: cover property ($rose(blank_o));

endmodule

// ===== rtl/tcagc_delay.sv
// Seconds-based hold-off timer for one monitored alarm condition.
// Assumes the condition and the seconds tick come from logic on the same clock.
`timescale 1ns/10ps
module tcagc_delay
	import tcagc_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        cond_i,
	input  wire logic        tick_i,
	input  wire logic [16:0] delay_s_i,
	output logic             report_o
);

	logic [16:0] cnt_r;
	logic        report_r;

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_r <= 17'h00000;
		end else if (!cond_i) begin
			cnt_r <= 17'h00000;
		end else if (tick_i && cnt_r != 17'h1FFFF) begin
			cnt_r <= cnt_r + 17'h00001;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			report_r <= 1'h0;
		end else begin
			report_r <= cond_i && cnt_r >= delay_s_i;
		end
	end

	assign report_o = report_r;

	delay_reached_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$rose(report_r) |-> $past(cond_i) && $past(cnt_r) >= $past(delay_s_i))
		else $error("report raised before the delay elapsed");
	short_loss_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!cond_i |=> !report_r)
		else $error("report held after the condition cleared");

endmodule

// ===== rtl/tcagc_pkg.sv
// Constants, types and helper functions for the timecode, alarm and GPI control block.
// Assumes a single 25 MHz module clock shared by every user of this package.
package tcagc_pkg;

	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned ALARM_HOLD_S   = 1;
	localparam int unsigned SEC_CYCLES_DEF = CLK_HZ * ALARM_HOLD_S;

	localparam logic [10:0] EPOCH_NEW_YEAR = 11'h7B2;
	localparam logic [10:0] EPOCH_OLD_YEAR = 11'h7A6;

	localparam logic [6:0]  SEXAGESIMAL    = 7'h3C;
	localparam logic [6:0]  HOURS_PER_DAY  = 7'h18;
	localparam logic [16:0] SEC_PER_HR     = 17'h0E10;
	localparam logic [16:0] SEC_PER_MIN    = 17'h0003C;
	localparam logic [4:0]  FPS_24         = 5'h18;
	localparam logic [4:0]  FPS_25         = 5'h19;
	localparam logic [4:0]  FPS_30         = 5'h1E;

	localparam logic [6:0]  JAM_MIN_FRAMES = 7'h64;
	localparam logic [5:0]  REACQ_READINGS = 6'h3C;
	localparam logic [3:0]  REACQ_MIN_SATS = 4'h4;

	// Output timecode delay limits, in microseconds.
	localparam logic [15:0] LIM_2398_US    = 16'h5172;
	localparam logic [15:0] LIM_24_US      = 16'h515E;
	localparam logic [15:0] LIM_25_US      = 16'h4E20;
	localparam logic [15:0] LIM_30_US      = 16'h411E;
	localparam logic [15:0] LIM_30DROP_US  = 16'h4128;

	typedef struct packed {
		logic [4:0] hh;
		logic [5:0] mm;
		logic [5:0] ss;
	} tcagc_hms_t;

	typedef struct packed {
		tcagc_hms_t hms;
		logic [4:0] ff;
	} tcagc_tc_t;

	typedef enum logic [2:0] {
		TCAGC_FMT_2398 = 3'h0,
		TCAGC_FMT_24 = 3'h1,
		TCAGC_FMT_25 = 3'h2,
		TCAGC_FMT_30 = 3'h3,
		TCAGC_FMT_THIRTY_FPS_DROP_FRAME = 3'h4
	} tcagc_fmt_t;

	typedef enum logic [2:0] {
		TCAGC_SRC_DISABLED = 3'h0,
		TCAGC_SRC_LOCAL_TIME_WITH_DAYLIGHT_SAVING = 3'h1,
		TCAGC_SRC_LOCAL_TIME_WITHOUT_DAYLIGHT_SAVING = 3'h2,
		TCAGC_SRC_UTC = 3'h3,
		TCAGC_SRC_PROGRAM_TIME = 3'h4
	} tcagc_src_t;

	typedef enum logic [1:0] {
		TCAGC_GPI_NONE = 2'h0,
		TCAGC_GPI_RESET_PT = 2'h1,
		TCAGC_GPI_REACQUIRE = 2'h2,
		TCAGC_GPI_JAM_SYNC = 2'h3
	} tcagc_gpi_fn_t;

	typedef enum logic [1:0] {
		TCAGC_GPO_NONE = 2'h0,
		TCAGC_GPO_SIG_WARN = 2'h1,
		TCAGC_GPO_LOSS_LOCK = 2'h2,
		TCAGC_GPO_ALARM_TIME = 2'h3
	} tcagc_gpo_sel_t;

	typedef enum logic {
		TCAGC_REF_SATELLITE = 1'h0,
		TCAGC_REF_VERTICAL_INTERVAL_TIMECODE_MODE = 1'h1
	} tcagc_ref_t;

	typedef enum logic [2:0] {
		TCAGC_RQ_IDLE = 3'b001,
		TCAGC_RQ_GATHER = 3'b010,
		TCAGC_RQ_STORE = 3'b100
	} tcagc_rq_st_t;

	typedef struct packed {
		tcagc_tc_t local_time_with_daylight_saving;
		tcagc_tc_t local_std;
		tcagc_tc_t utc;
	} tcagc_tod_t;

	typedef struct packed {
		logic                epoch_1958;
		logic                alarm_en;
		tcagc_hms_t          alarm_time;
		tcagc_hms_t          lol_delay;
		tcagc_hms_t          warn_delay;
		tcagc_hms_t          blank_delay;
		logic                blank_en;
		logic                port_out;
		tcagc_fmt_t          fmt;
		tcagc_src_t          src;
		tcagc_tc_t           offset;
		logic signed [15:0]  delay_us;
		tcagc_gpi_fn_t       gpi_fn;
		tcagc_gpo_sel_t      gpo_sel;
	} tcagc_cfg_t;

	localparam tcagc_cfg_t CFG_RST = '{
		epoch_1958: 1'h0, alarm_en: 1'h0, alarm_time: 17'h00000,
		lol_delay: 17'h00000, warn_delay: 17'h00000, blank_delay: 17'h00000,
		blank_en: 1'h0, port_out: 1'h0, fmt: TCAGC_FMT_25,
		src: TCAGC_SRC_LOCAL_TIME_WITH_DAYLIGHT_SAVING, offset: 22'h000000,
		delay_us: 16'sh0000, gpi_fn: TCAGC_GPI_NONE, gpo_sel: TCAGC_GPO_NONE};

	function automatic logic [16:0] hms_to_s(tcagc_hms_t t);
		hms_to_s = 17'(t.hh) * SEC_PER_HR + 17'(t.mm) * SEC_PER_MIN + 17'(t.ss);
	endfunction

	function automatic logic [4:0] fmt_fps(tcagc_fmt_t f);
		case (f)
			TCAGC_FMT_25: fmt_fps = FPS_25;
			TCAGC_FMT_30, TCAGC_FMT_THIRTY_FPS_DROP_FRAME: fmt_fps = FPS_30;
			default: fmt_fps = FPS_24;
		endcase
	endfunction

	function automatic logic [15:0] fmt_lim(tcagc_fmt_t f);
		case (f)
			TCAGC_FMT_24: fmt_lim = LIM_24_US;
			TCAGC_FMT_25: fmt_lim = LIM_25_US;
			TCAGC_FMT_30: fmt_lim = LIM_30_US;
			TCAGC_FMT_THIRTY_FPS_DROP_FRAME: fmt_lim = LIM_30DROP_US;
			default: fmt_lim = LIM_2398_US;
		endcase
	endfunction

	// Adds two timecodes with carries, wrapping at one day; drop-frame numbering is not applied.
	function automatic tcagc_tc_t tc_add(tcagc_tc_t a, tcagc_tc_t b, logic [4:0] fps);
		logic [6:0] s;
		logic       c;
		tc_add = '0;
		s = 7'(a.ff) + 7'(b.ff);
		c = s >= 7'(fps);
		tc_add.ff = 5'(c ? s - 7'(fps) : s);
		s = 7'(a.hms.ss) + 7'(b.hms.ss) + 7'(c);
		c = s >= SEXAGESIMAL;
		tc_add.hms.ss = 6'(c ? s - SEXAGESIMAL : s);
		s = 7'(a.hms.mm) + 7'(b.hms.mm) + 7'(c);
		c = s >= SEXAGESIMAL;
		tc_add.hms.mm = 6'(c ? s - SEXAGESIMAL : s);
		s = 7'(a.hms.hh) + 7'(b.hms.hh) + 7'(c);
		c = s >= HOURS_PER_DAY;
		tc_add.hms.hh = 5'(c ? s - HOURS_PER_DAY : s);
	endfunction

endpackage
